/* logic/vig_glue.sv */
// Vectored interrupt glue between UART requests and an 8-bit processor
`timescale 1ns/10ps
`default_nettype none
module vig_glue #(
    parameter int NUM_SRC = 8,
    parameter logic [2:0] FIRST_RST = 3'h4
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [NUM_SRC-1:0] UART_IRQ_N,
    input wire logic IRQ_ACK_N,
    input wire logic CPU_IRQ_ENABLED,
    input wire logic [NUM_SRC-1:0] IRQ_PIN_MODE,
    output logic CPU_IRQ,
    output logic EXT_IRQ0_N,
    output logic [7:0] VEC_DATA,
    output logic VEC_OE_N,
    output logic [NUM_SRC-1:0] SRC_OE_N,
    output vig_pkg::vig_bus_s VEC_BUS,
    output logic [2:0] LAST_RST_REG
);
    import vig_pkg::*;

    // Opcode for restart n: C7 plus 8*n
    function automatic logic [7:0] rst_opcode(input logic [2:0] n);
        rst_opcode = VIG_RST_BASE + {2'b00, n, 3'b000};
    endfunction : rst_opcode

    // Restart number of the granted source; zero when none is on
    function automatic logic [2:0] grant_rst(input logic [NUM_SRC-1:0] g);
        grant_rst = 3'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (g[i]) begin
                grant_rst = FIRST_RST + i[2:0];
            end
        end
    endfunction : grant_rst

    logic [2:0] served_rst;

    logic [NUM_SRC-1:0] req_act;
    logic [NUM_SRC-1:0] oe_n;
    logic [NUM_SRC-1:0] prio_grant;
    logic [7:0] or_data;
    logic [2:0] last_rst_next;
    logic [2:0] last_rst_reg;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            // Only pin-mode sources count as interrupt lines
            assign req_act[gi] = ~UART_IRQ_N[gi] & IRQ_PIN_MODE[gi];
            // Lowest index wins so two buffers never fight on the bus
            if (gi == 0) begin : g_first
                assign prio_grant[gi] = req_act[gi];
            end else begin : g_rest
                assign prio_grant[gi] = req_act[gi] & ~|req_act[gi-1:0];
            end
            // OR of inverted priority grant and acknowledge, per source
            assign oe_n[gi] = ~prio_grant[gi] | IRQ_ACK_N;
        end
    endgenerate

    always_comb begin
        or_data = 8'h00;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (!oe_n[i]) begin
                or_data = rst_opcode(FIRST_RST + i[2:0]);
            end
        end
    end

    assign CPU_IRQ = |req_act;
    // Direct alternative uses the pin-mode requests, no acknowledge needed
    assign EXT_IRQ0_N = ~|req_act;
    assign SRC_OE_N = oe_n;
    assign VEC_OE_N = &oe_n;
    // Data is zero while released; bus wire resolves from the enable
    assign VEC_DATA = or_data;
    assign VEC_BUS = '{data: or_data, oe_n: &oe_n};
    assign LAST_RST_REG = last_rst_reg;
    // Only one grant can be on, so the decode never mixes two sources
    assign served_rst = grant_rst(~oe_n);

    // Remembers which restart was last served, for diagnostics
    always_comb begin
        last_rst_next = last_rst_reg;
        if (RST) begin
            last_rst_next = 3'h0;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (!oe_n[i]) begin
                    last_rst_next = FIRST_RST + i[2:0];
                end
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        last_rst_reg <= last_rst_next;
    end

    // Helpers for assertions
    sequence s_ack_low;
        !IRQ_ACK_N;
    endsequence

    AST_INVERT: assert property (@(posedge CLOCK) disable iff (RST)
        CPU_IRQ == |(~UART_IRQ_N & IRQ_PIN_MODE)) else $error("Request not inverted");
    AST_OE_OR: assert property (@(posedge CLOCK) disable iff (RST)
        (!VEC_OE_N) |-> (s_ack_low and CPU_IRQ)) else $error("Buffer on without both low");
    AST_OE_ON: assert property (@(posedge CLOCK) disable iff (RST)
        (s_ack_low and CPU_IRQ) |-> !VEC_OE_N) else $error("Buffer off while both low");
    AST_OPCODE: assert property (@(posedge CLOCK) disable iff (RST)
        (!VEC_OE_N && prio_grant[0]) |-> VEC_DATA == rst_opcode(FIRST_RST))
        else $error("Wrong opcode");
    AST_REL: assert property (@(posedge CLOCK) disable iff (RST)
        IRQ_ACK_N |-> (&SRC_OE_N && VEC_DATA == 8'h00)) else $error("Bus not released");
    AST_ONEHOT: assert property (@(posedge CLOCK) disable iff (RST)
        $onehot0(~SRC_OE_N)) else $error("Two buffers on");
    AST_OPC_RANGE: assert property (@(posedge CLOCK) disable iff (RST)
        !VEC_OE_N |-> VEC_DATA[2:0] == 3'h7 && VEC_DATA[7:6] == 2'b11)
        else $error("Not a restart opcode");
    AST_DIRECT: assert property (@(posedge CLOCK) disable iff (RST)
        EXT_IRQ0_N == !CPU_IRQ) else $error("Direct line mismatch");
    AST_LAST: assert property (@(posedge CLOCK) disable iff (RST)
        (!VEC_OE_N && prio_grant[0]) |=> LAST_RST_REG == FIRST_RST)
        else $error("Served restart not recorded");

    // Steps of one vectored service: request, acknowledge with byte on bus, then quiet
    sequence s_req_up;
        CPU_IRQ && IRQ_ACK_N;
    endsequence

    sequence s_served;
        !VEC_OE_N && !IRQ_ACK_N;
    endsequence

    sequence s_quiet;
        !CPU_IRQ && EXT_IRQ0_N;
    endsequence

    AST_LAST_ANY: assert property (@(posedge CLOCK) disable iff (RST)
        s_served |=> LAST_RST_REG == $past(served_rst))
        else $error("Served restart number lost");

    AST_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
        VEC_OE_N |=> LAST_RST_REG == $past(LAST_RST_REG))
        else $error("Restart record moved without service");

    AST_QUIET: assert property (@(posedge CLOCK) disable iff (RST)
        &(UART_IRQ_N | ~IRQ_PIN_MODE) |-> s_quiet)
        else $error("Request still up with no cause");

    AST_NO_REQ: assert property (@(posedge CLOCK) disable iff (RST)
        !CPU_IRQ |-> VEC_OE_N && VEC_DATA == 8'h00)
        else $error("Bus driven with no requester");

    AST_MIRROR: assert property (@(posedge CLOCK) disable iff (RST)
        VEC_BUS.data == VEC_DATA && VEC_BUS.oe_n == VEC_OE_N)
        else $error("Carrier differs from bus pins");

    AST_ALL_OE: assert property (@(posedge CLOCK) disable iff (RST)
        VEC_OE_N == &SRC_OE_N)
        else $error("Shared enable differs from sources");

    // Request seen first, then acknowledge with request still up
    AST_SERVE: assert property (@(posedge CLOCK) disable iff (RST)
        (s_req_up ##1 (CPU_IRQ && !IRQ_ACK_N)) |-> s_served)
        else $error("Acknowledge not answered");

    AST_ACK_OFF: assert property (@(posedge CLOCK) disable iff (RST)
        IRQ_ACK_N |-> VEC_OE_N)
        else $error("Buffer on outside acknowledge");

    // Reset checked without the disable, so the clear itself is seen
    AST_RST_CLR: assert property (@(posedge CLOCK)
        RST |=> LAST_RST_REG == 3'h0)
        else $error("Restart record not cleared");

    genvar ai;
    generate
        for (ai = 0; ai < NUM_SRC; ai++) begin : g_chk
            AST_SRC_OPC: assert property (@(posedge CLOCK) disable iff (RST)
                !SRC_OE_N[ai] |-> VEC_DATA == rst_opcode(3'(FIRST_RST + ai)))
                else $error("Source opcode wrong");

            AST_SRC_MASK: assert property (@(posedge CLOCK) disable iff (RST)
                !IRQ_PIN_MODE[ai] |-> SRC_OE_N[ai])
                else $error("Masked source drove the bus");

            AST_SRC_OWN: assert property (@(posedge CLOCK) disable iff (RST)
                !SRC_OE_N[ai] |-> !UART_IRQ_N[ai] && !IRQ_ACK_N)
                else $error("Source buffer on without its own request");
        end
    endgenerate
endmodule : vig_glue
`default_nettype wire

/* logic/vig_pkg.sv */
// Package for the vectored interrupt glue: opcodes and carrier types
package vig_pkg;
    localparam int VIG_MAX_SRC = 8;
    localparam int VIG_BYTE_W = 8;
    localparam logic [7:0] VIG_RST_BASE = 8'hC7;
    localparam logic [7:0] VIG_RST_STEP = 8'h08;
    localparam logic [2:0] VIG_REF_RST = 3'h4;
    localparam logic [7:0] VIG_REF_OPCODE = 8'hE7;
    localparam logic [15:0] VIG_REF_ADDR = 16'h0020;
    localparam logic [15:0] VIG_DIRECT_ADDR = 16'h0003;
    localparam logic [15:0] VIG_RST_ADDR_STEP = 16'h0008;
    localparam int VIG_EXT_SPACE = 256;

    typedef struct packed {
        logic [7:0] data;
        logic oe_n;
    } vig_bus_s;

    typedef enum logic [1:0] {
        VIG_IDLE,
        VIG_REQ,
        VIG_ACK
    } vig_phase_e;
endpackage : vig_pkg

/* sim/vig_cpu_model.sv */
// Processor-side model: takes requests, acknowledges, loads restart address
`timescale 1ns/10ps
`default_nettype none
module vig_cpu_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic cpu_irq,
    input wire logic irq_enabled,
    input wire logic [7:0] vec_data,
    output logic irq_ack_n,
    output logic [15:0] pc_reg
);
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_ack_n <= 1'b1;
            pc_reg <= 16'h0000;
        end else begin
            // One cycle stands for finishing the current instruction
            irq_ack_n <= !(cpu_irq && irq_enabled);
            // Only a restart opcode is executed; an empty bus is ignored
            if (!irq_ack_n && vec_data[2:0] == 3'h7 && vec_data[7:6] == 2'b11) begin
                pc_reg <= {10'h000, vec_data[5:3], 3'h0};
            end
        end
    end
endmodule : vig_cpu_model
`default_nettype wire

/* sim/vig_glue_tb_top.sv */
// Random and corner-case bench for the vectored interrupt glue
`timescale 1ns/10ps
`default_nettype none
module vig_glue_tb_top;
    logic clock = 0, rst = 1, en = 0, ack_n, irq, ext_n, oe_n;
    logic [7:0] irq_n = 8'hff, mode = 8'h00, data, src;
    logic [15:0] pc, pc_exp = 16'h0000;
    logic [2:0] last, last_exp = 3'h0;
    logic prev_srv = 1'b0, prev_rst = 1'b1;
    logic [7:0] prev_d = 8'h00;
    vig_pkg::vig_bus_s bus;
    int errors = 0, checks_done = 0, seed = 32'hd13b;
    logic [17:0] e;
    initial forever #20 clock = ~clock;
    vig_glue DUT (.CLOCK(clock), .RST(rst), .UART_IRQ_N(irq_n), .IRQ_ACK_N(ack_n),
        .CPU_IRQ_ENABLED(en), .IRQ_PIN_MODE(mode), .CPU_IRQ(irq), .EXT_IRQ0_N(ext_n),
        .VEC_DATA(data), .VEC_OE_N(oe_n), .SRC_OE_N(src), .VEC_BUS(bus), .LAST_RST_REG(last));
    vig_cpu_model cpu (.clock(clock), .rst(rst), .cpu_irq(irq), .irq_enabled(en),
        .vec_data(data), .irq_ack_n(ack_n), .pc_reg(pc));
    // Expected {irq, oe_n, data, per-source enables}; lowest index wins
    function automatic logic [17:0] exp_f(logic [7:0] n, logic [7:0] m, logic a);
        logic [7:0] act, d, s;
        act = ~n & m;
        d = 8'h00;
        s = 8'hff;
        for (int i = 7; i >= 0; i--) begin
            if (act[i] && !a) begin
                d = 8'hc7 + 8'h08 * 8'((4 + i) % 8);
                s = ~(8'h01 << i);
            end
        end
        return {|act, !(|act && !a), d, s};
    endfunction : exp_f
    task automatic chk(string nm, logic [17:0] x, logic [17:0] g);
        checks_done++;
        if (x !== g) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        // Cut short a hung run well past the expected span
        #(40 * 700);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clock);
        #1 rst = 0;
        for (int k = 0; k < 403; k++) begin
            @(posedge clock);
            #1;
            // One-cycle reset in mid-run
            rst = k == 200;
            // Corners first: all requesting, all masked, only the top source
            irq_n = k == 0 ? 8'h00 : k == 1 ? 8'h00 : k == 2 ? 8'h7f : 8'($random(seed));
            mode = k == 1 ? 8'h00 : k < 3 ? 8'hff : 8'($random(seed));
            en = k < 3 ? 1'b1 : 1'($random(seed));
            @(negedge clock);
            // Restart address is the opcode less C7; number is that over eight
            if (prev_rst) begin
                pc_exp = 16'h0000;
                last_exp = 3'h0;
            end else if (prev_srv) begin
                pc_exp = 16'(prev_d - 8'hc7);
                last_exp = 3'((prev_d - 8'hc7) >> 3);
            end
            e = exp_f(irq_n, mode, ack_n);
            chk("irq", 18'(e[17]), 18'(irq));
            chk("ext", 18'(!e[17]), 18'(ext_n));
            chk("oe", 18'(e[16]), 18'(oe_n));
            chk("data", 18'(e[15:8]), 18'(data));
            chk("src", 18'(e[7:0]), 18'(src));
            chk("bus", 18'({e[15:8], e[16]}), 18'(bus));
            chk("pc", 18'(pc_exp), 18'(pc));
            chk("last", 18'(last_exp), 18'(last));
            prev_srv = !e[16];
            prev_d = e[15:8];
            prev_rst = rst;
        end
        print_verdict();
    end
endmodule : vig_glue_tb_top
`default_nettype wire
